/* File: design/tbe_pkg.sv */
// shared widths, reset values and rate figures of the transmit coding path
package tbe_pkg;
   localparam int BYTE_W = 8;                  // one fabric byte
   localparam int WORD_W = 2 * BYTE_W;         // two-byte fabric word
   localparam int CODE_W = 10;                 // one 8b/10b code group
   localparam int FIFO_DEPTH = 16;             // words held ahead of coder
   localparam logic RD_RESET = 1'b0;           // running disparity negative
   localparam logic [5:0] K28_6B = 6'h0f;      // 001111 at negative disparity
   localparam logic [3:0] ALT7_4B = 4'h7;      // 0111 alternate x.7 form
   localparam logic [4:0] K28_X = 5'h1c;       // low five bits of K28.y
   localparam logic [2:0] Y7 = 3'h7;           // 3b value 7
   localparam logic [2:0] Y3 = 3'h3;           // 3b value 3
   localparam logic [4:0] X7 = 5'h07;          // 5b value 7
   // line rate against fabric clock: serial bits per fabric clock
   localparam int LINE_RATE_MBPS = 3125;       // highest line rate served
   localparam int SER_RATIO = 20;              // bits per word, serializer on
   localparam int NOSER_RATIO = 10;            // bits per byte, serializer off
   localparam int FABRIC_KHZ_SER = LINE_RATE_MBPS * 1000 / SER_RATIO;
   localparam int BYTES_PER_WORD = SER_RATIO / NOSER_RATIO;
endpackage : tbe_pkg

/* File: design/tbe_fifo.sv */
// word FIFO with registered read data, between fabric and coder
module tbe_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input wire logic clk,                    // core clock
   input wire logic rst,                    // synchronous reset, high
   input wire logic in_valid,               // writer offers a word
   output logic in_ready,                   // room for a word, registered
   input wire logic [WIDTH-1:0] in_data,    // word written
   output logic out_valid,                  // read word present, registered
   input wire logic out_ready,              // reader takes the word
   output logic [WIDTH-1:0] out_data        // read word, registered
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
         $error("tbe_fifo: depth must be a power of two of at least two");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic room;
      logic o_valid;
      logic [WIDTH-1:0] o_data;
   } tbe_fifo_s;

   tbe_fifo_s st_r;
   tbe_fifo_s st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // push into the array, pop into the output register
   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      st_nxt = st_r;
      push = in_valid && st_r.room;
      // output register refills only when empty or taken this cycle
      pop = (st_r.cnt != '0) && (!st_r.o_valid || out_ready);
      if (out_ready) begin
         st_nxt.o_valid = 1'b0;
      end
      if (push) begin
         st_nxt.mem[st_r.wr] = in_data;
         st_nxt.wr = st_r.wr + 1'b1;
      end
      if (pop) begin
         st_nxt.o_data = st_r.mem[st_r.rd];
         st_nxt.o_valid = 1'b1;
         st_nxt.rd = st_r.rd + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      // room is registered so the fabric sees a clean flop; costs no slot
      st_nxt.room = (st_nxt.cnt != DEPTH[AW:0]);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.room <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign in_ready = st_r.room;
   assign out_valid = st_r.o_valid;
   assign out_data = st_r.o_data;
endmodule : tbe_fifo

/* File: design/tbe_tx_coder.sv */
// transmit byte serializer and 8b/10b encoder of one transceiver channel
//
// Behaviour
// - Serializer on: each word leaves low byte first, then high byte.
// - Serializer on: one word per two slots, fabric at line rate / 20.
// - Encoder on: byte and flag make one 10-bit group, disparity right.
// - A flagged byte gives K28.y if x is 28, else Dx.y with alternate x.7 forced; an unflagged byte gives Dx.y.
// - Code tables and disparity follow standard 8b/10b data and K coding.
// - A flag on a non-special byte raises no error; the tables decide.
module tbe_tx_coder
   import tbe_pkg::*;
#(
   parameter int FIFO_DEPTH = tbe_pkg::FIFO_DEPTH
) (
   input wire logic clk,                            // byte-rate clock
   input wire logic rst,                            // synchronous reset, high
   input wire logic ser_en,                         // byte serializer on
   input wire logic enc_en,                         // 8b/10b encoder on
   input wire logic tx_valid,                       // fabric offers a word
   output logic tx_ready,                           // word taken, registered
   input wire logic [tbe_pkg::WORD_W-1:0] tx_word,  // high byte, low byte
   input wire logic [1:0] tx_ctrl,                  // control flag per byte
   output logic line_valid,                         // code group present
   input wire logic line_ready,                     // line takes the group
   output logic [tbe_pkg::CODE_W-1:0] line_code,    // bit 9 goes out first
   output logic line_rd                             // disparity after group
);
   import tbe_pkg::*;

   localparam int FW = WORD_W + 2;

   generate
      if (FIFO_DEPTH < 16) begin : g_chk
         $error("tbe_tx_coder: fifo depth below one burst of sixteen");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // 8b/10b lookup and disparity helpers

   // 5b/6b group abcdei, as sent at negative disparity
   function automatic logic [5:0] tbe_tbl6(input logic [4:0] x);
      case (x)
         5'h00: tbe_tbl6 = 6'h27;
         5'h01: tbe_tbl6 = 6'h1d;
         5'h02: tbe_tbl6 = 6'h2d;
         5'h03: tbe_tbl6 = 6'h31;
         5'h04: tbe_tbl6 = 6'h35;
         5'h05: tbe_tbl6 = 6'h29;
         5'h06: tbe_tbl6 = 6'h19;
         5'h07: tbe_tbl6 = 6'h38;
         5'h08: tbe_tbl6 = 6'h39;
         5'h09: tbe_tbl6 = 6'h25;
         5'h0a: tbe_tbl6 = 6'h15;
         5'h0b: tbe_tbl6 = 6'h34;
         5'h0c: tbe_tbl6 = 6'h0d;
         5'h0d: tbe_tbl6 = 6'h2c;
         5'h0e: tbe_tbl6 = 6'h1c;
         5'h0f: tbe_tbl6 = 6'h17;
         5'h10: tbe_tbl6 = 6'h1b;
         5'h11: tbe_tbl6 = 6'h23;
         5'h12: tbe_tbl6 = 6'h13;
         5'h13: tbe_tbl6 = 6'h32;
         5'h14: tbe_tbl6 = 6'h0b;
         5'h15: tbe_tbl6 = 6'h2a;
         5'h16: tbe_tbl6 = 6'h1a;
         5'h17: tbe_tbl6 = 6'h3a;
         5'h18: tbe_tbl6 = 6'h33;
         5'h19: tbe_tbl6 = 6'h26;
         5'h1a: tbe_tbl6 = 6'h16;
         5'h1b: tbe_tbl6 = 6'h36;
         5'h1c: tbe_tbl6 = 6'h0e;
         5'h1d: tbe_tbl6 = 6'h2e;
         5'h1e: tbe_tbl6 = 6'h1e;
         default: tbe_tbl6 = 6'h2b;
      endcase
   endfunction : tbe_tbl6

   // 3b/4b group fghj, primary form at negative disparity
   function automatic logic [3:0] tbe_tbl4(input logic [2:0] y);
      case (y)
         3'h0: tbe_tbl4 = 4'hb;
         3'h1: tbe_tbl4 = 4'h9;
         3'h2: tbe_tbl4 = 4'h5;
         3'h3: tbe_tbl4 = 4'hc;
         3'h4: tbe_tbl4 = 4'hd;
         3'h5: tbe_tbl4 = 4'ha;
         3'h6: tbe_tbl4 = 4'h6;
         default: tbe_tbl4 = 4'he;
      endcase
   endfunction : tbe_tbl4

   // ones in a six-bit field, used for both sub-blocks
   function automatic logic [2:0] tbe_ones(input logic [5:0] v);
      tbe_ones = 3'h0;
      for (int i = 0; i < 6; i++) begin
         tbe_ones = tbe_ones + {2'h0, v[i]};
      end
   endfunction : tbe_ones

   // one byte to one group; returns {disparity after, code group}
   function automatic logic [CODE_W:0] tbe_encode(
      input logic [BYTE_W-1:0] b,
      input logic k,
      input logic rd
   );
      logic [4:0] x;
      logic [2:0] y;
      logic [5:0] t6;
      logic [3:0] t4;
      logic rd6;
      logic alt;
      logic bal4;
      logic comp4;
      x = b[4:0];
      y = b[7:5];
      // a flag on any byte just selects K28 6b when x is 28
      t6 = (k && x == K28_X) ? K28_6B : tbe_tbl6(x);
      // unbalanced groups and D.7 take the inverted form at positive rd
      if (rd && (tbe_ones(t6) != 3'h3 || x == X7)) begin
         t6 = ~t6;
      end
      rd6 = (tbe_ones(t6) != 3'h3) ? ~rd : rd;
      // alternate x.7 avoids a run of five; control groups always use it
      alt = (y == Y7) && (k || (!rd6 && (x == 5'h11 || x == 5'h12 ||
         x == 5'h14)) || (rd6 && (x == 5'h0b || x == 5'h0d ||
         x == 5'h0e)));
      t4 = alt ? ALT7_4B : tbe_tbl4(y);
      bal4 = (tbe_ones({2'h0, t4}) == 3'h2);
      comp4 = rd6 && (!bal4 || y == Y3);
      // balanced K28.1/.2/.5/.6 flip with disparity to keep the comma
      if (k && x == K28_X && bal4 && y != Y3) begin
         comp4 = !rd6;
      end
      if (comp4) begin
         t4 = ~t4;
      end
      tbe_encode = {(bal4 ? rd6 : ~rd6), t6, t4};
   endfunction : tbe_encode

   ////////////////////////////////////////////////////////////////////////
   // fabric words are buffered so a stalled line back-pressures tx_ready

   logic f_valid;
   logic f_ready;
   logic [FW-1:0] f_data;

   tbe_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_ctrl, tx_word}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // coder state

   typedef struct packed {
      logic hi_pend;                // high byte of last word still owed
      logic [BYTE_W-1:0] hi_byte;   // that high byte
      logic hi_k;                   // its control flag
      logic rd;                     // running disparity, 1 means positive
      logic o_valid;
      logic [CODE_W-1:0] o_code;
   } tbe_coder_s;

   tbe_coder_s st_r;
   tbe_coder_s st_nxt;
   logic slot;

   // one byte slot per clock whenever the output register can move on
   assign slot = !st_r.o_valid || line_ready;
   // a new word is pulled only in a slot with no high byte owed
   assign f_ready = slot && !st_r.hi_pend;

   ////////////////////////////////////////////////////////////////////////
   // byte selection and encoding
   always_comb begin
      logic [BYTE_W-1:0] byte_v;
      logic k_v;
      logic go;
      logic [CODE_W:0] enc;
      byte_v = '0;
      k_v = 1'b0;
      go = 1'b0;
      enc = '0;
      st_nxt = st_r;
      if (line_ready) begin
         st_nxt.o_valid = 1'b0;
      end
      if (slot && st_r.hi_pend) begin
         // second slot of a word: the high byte follows the low one
         byte_v = st_r.hi_byte;
         k_v = st_r.hi_k;
         go = 1'b1;
         st_nxt.hi_pend = 1'b0;
      end else if (f_ready && f_valid) begin
         byte_v = f_data[BYTE_W-1:0];
         k_v = f_data[WORD_W];
         go = 1'b1;
         // serializer off: the high byte is dropped, one byte per word
         st_nxt.hi_pend = ser_en;
         st_nxt.hi_byte = f_data[WORD_W-1:BYTE_W];
         st_nxt.hi_k = f_data[WORD_W+1];
      end
      if (go) begin
         enc = tbe_encode(byte_v, k_v, st_r.rd);
         st_nxt.o_valid = 1'b1;
         if (enc_en) begin
            st_nxt.o_code = enc[CODE_W-1:0];
            st_nxt.rd = enc[CODE_W];
         end else begin
            // bypass carries the raw byte; disparity is left alone
            st_nxt.o_code = {2'h0, byte_v};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.rd <= RD_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign line_valid = st_r.o_valid;
   assign line_code = st_r.o_code;
   assign line_rd = st_r.rd;
endmodule : tbe_tx_coder

/* File: test/tbe_tx_coder_sva.sv */
// port checker of the transmit coding path
module tbe_tx_coder_sva
   import tbe_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk, // core clock
   input wire logic rst, // reset, high
   input wire logic ser_en, // serializer on
   input wire logic enc_en, // encoder on
   input wire logic tx_valid, // word offered
   input wire logic tx_ready, // room for a word
   input wire logic [tbe_pkg::WORD_W-1:0] tx_word, // fabric word
   input wire logic [1:0] tx_ctrl, // flags
   input wire logic line_valid, // group present
   input wire logic line_ready, // group taken
   input wire logic [tbe_pkg::CODE_W-1:0] line_code, // group
   input wire logic line_rd // disparity
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   chk_reset_state: assert property (disable iff (1'b0)
      rst |=> !line_valid && !line_rd && tx_ready) else $error("reset state");
   chk_group_hold: assert property (line_valid && !line_ready |=>
      line_valid && $stable(line_code) && $stable(line_rd))
      else $error("hold");
   chk_first_group: assert property (tx_valid && tx_ready &&
      !line_valid |-> ##[1:3] line_valid) else $error("group late");
   chk_ready_fall: assert property ($fell(tx_ready) |->
      $past(tx_valid)) else $error("ready fell without a write");
   chk_bypass_form: assert property (line_valid && !enc_en |->
      line_code[9:8] == 2'b00) else $error("bypass form");
   chk_bypass_rd: assert property (line_valid && line_ready &&
      !enc_en |=> $stable(line_rd)) else $error("bypass disparity");
   chk_code_weight: assert property (line_valid && enc_en |->
      $countones(line_code) inside {4, 5, 6}) else $error("group weight");
   chk_rd_follows: assert property (enc_en && line_valid &&
      $countones(line_code) != 5 |-> line_rd == ($countones(line_code) == 6))
      else $error("disparity flag");
   chk_rd_chain: assert property (enc_en && line_valid &&
      line_ready ##1 (line_valid && $countones(line_code) == 6) |->
      !$past(line_rd)) else $error("heavy group at positive disparity");
endmodule : tbe_tx_coder_sva
bind tbe_tx_coder tbe_tx_coder_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
   .clk(clk), .rst(rst), .ser_en(ser_en), .enc_en(enc_en),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
   .tx_ctrl(tx_ctrl), .line_valid(line_valid), .line_ready(line_ready),
   .line_code(line_code), .line_rd(line_rd));

/* File: test/tbe_fabric_model.sv */
// fabric model: offers words with random gaps, holds each until taken
module tbe_fabric_model (
   input wire logic clk, // core clock
   input wire logic rst, // reset, high
   input wire logic run, // keep offering words
   input wire logic tx_ready, // coder takes the word
   output logic tx_valid, // word offered
   output logic [15:0] tx_word, // high byte, low byte
   output logic [1:0] tx_ctrl // flag per byte
);
   timeunit 1ns;
   timeprecision 100ps;
   logic tk, r0, go;
   logic [8:0] lo, hi;
   // one pick in eight flags a comma-family byte; 8'hbc also goes out as plain data;
   // now and then a flagged plain byte tries the no-error path
   function automatic logic [8:0] pick();
      int r;
      r = $urandom_range(7, 0);
      if (r == 0) return {1'b1, 3'($urandom), 5'h1c};
      if (r == 1) return 9'h0bc;
      if (r == 2) return {1'b1, 8'($urandom)};
      return {1'b0, 8'($urandom)};
   endfunction : pick
   initial begin
      tx_valid = 1'b0;
      tx_word = 16'h0000;
      tx_ctrl = 2'h0;
   end
   // word held until taken; idle data toggles so stale values never match
   always @(posedge clk) begin
      tk = tx_valid && tx_ready;
      r0 = rst;
      go = run;
      #1;
      if (r0 || ((tk || !tx_valid) && !(go && $urandom_range(1, 0)))) begin
         tx_valid = 1'b0;
         tx_word = ~tx_word;
      end else if (tk || !tx_valid) begin
         lo = pick();
         hi = pick();
         tx_valid = 1'b1;
         tx_word = {hi[7:0], lo[7:0]};
         tx_ctrl = {hi[8], lo[8]};
      end
   end
endmodule : tbe_fabric_model

/* File: test/test_tbe_tx_coder.sv */
// self-checking bench of the transmit coding path
module test_tbe_tx_coder;
   timeunit 1ns;
   timeprecision 100ps;
   import tbe_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ser_en = 1'b0, enc_en = 1'b0, run = 1'b0;
   logic line_ready = 1'b0, mrd = 1'b0;
   logic tx_valid, tx_ready, line_valid, line_rd;
   logic [WORD_W-1:0] tx_word;
   logic [1:0] tx_ctrl;
   logic [CODE_W-1:0] line_code;
   logic [8:0] exp_q[$];
   logic [8:0] e;
   logic [10:0] r;
   int error_cnt = 0, checks_done = 0, cyc = 0, lr_mode = 0, m_s = 0;
   // 6b and 4b groups at negative disparity, abcdei and fghj
   localparam logic [5:0] D6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35,
      6'h29, 6'h19, 6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c,
      6'h17, 6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33,
      6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] F4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha,
      4'h6, 4'he};
   always #2 clk = ~clk;
   tbe_tx_coder u_dut (.clk(clk), .rst(rst), .ser_en(ser_en),
      .enc_en(enc_en), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_word(tx_word), .tx_ctrl(tx_ctrl), .line_valid(line_valid),
      .line_ready(line_ready), .line_code(line_code), .line_rd(line_rd));
   tbe_fabric_model u_fab (.clk(clk), .rst(rst), .run(run),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_word(tx_word),
      .tx_ctrl(tx_ctrl));
   ////////////////////////////////////////////////////////////////////////
   // reference coder; K28 groups built at negative disparity, then inverted
   // at positive disparity; any other flagged byte takes the data path with forced x.7
   function automatic logic [10:0] enc8b(input logic [7:0] b,
      input logic k, input logic rd);
      logic [5:0] s;
      logic [3:0] f;
      logic q;
      logic alt;
      int x;
      x = b[4:0];
      q = (k && x == 28) ? 1'b0 : rd;
      s = (k && x == 28) ? 6'h0f : D6[x];
      if (q && ($countones(s) != 3 || x == 7)) s = ~s;
      if ($countones(s) != 3) q = ~q;
      alt = b[7:5] == 3'h7 && (k || (!q && (x == 17 || x == 18 || x == 20))
         || (q && (x == 11 || x == 13 || x == 14)));
      f = alt ? 4'h7 : F4[b[7:5]];
      if (q && ($countones(f) != 2 || b[7:5] == 3'h3)) f = ~f;
      if ($countones(f) != 2) q = ~q;
      if (k && x == 28) return {rd ^ q, rd ? ~{s, f} : {s, f}};
      return {q, s, f};
   endfunction : enc8b
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////
   // expected bytes from accepted words, compared at every taken group
   always @(posedge clk) begin
      if (rst) begin
         mrd = 1'b0;
         exp_q.delete();
      end else begin
         if (tx_valid && tx_ready === 1'b1) begin
            exp_q.push_back({tx_ctrl[0], tx_word[7:0]});
            if (ser_en) exp_q.push_back({tx_ctrl[1], tx_word[15:8]});
         end
         if (line_valid === 1'b1 && line_ready) begin
            if (exp_q.size() == 0) begin
               check(16'h0001, 16'h0000);
            end else begin
               e = exp_q.pop_front();
               r = enc_en ? enc8b(e[7:0], e[8], mrd) : {mrd, 2'b00, e[7:0]};
               mrd = r[10];
               check({5'h00, line_rd, line_code}, {5'h00, r});
            end
         end
      end
   end
   // line side readiness and the hang limit; the line stalls at random
   always @(posedge clk) begin
      m_s = lr_mode;
      #1;
      line_ready = (m_s == 2) || (m_s == 1 && $urandom_range(1, 0));
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         print_verdict();
      end
   end
   // every serializer and encoder mode: traffic, fill until refused, drain
   initial begin
      void'($urandom(14895));
      for (int m = 0; m < 4; m++) begin
         rst = 1'b1;
         {ser_en, enc_en} = 2'(m);
         run = 1'b0;
         lr_mode = 0;
         repeat (20) @(posedge clk);
         #1 rst = 1'b0;
         run = 1'b1;
         lr_mode = 1;
         repeat (200) @(posedge clk);
         #1 lr_mode = 0;
         repeat (80) @(posedge clk);
         #1 check(16'(tx_ready), 16'h0000);
         run = 1'b0;
         lr_mode = 2;
         for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk);
         repeat (8) @(posedge clk);
         #1 check(16'(line_valid), 16'h0000);
         check(16'(exp_q.size()), 16'h0000);
         check(16'(tx_ready), 16'h0001);
      end
      print_verdict();
   end
endmodule : test_tbe_tx_coder
